// File: ccr_pkg.sv
// shared constants for the comparator c/d configuration register bank
package ccr_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // printed offsets are word indices; byte address is four times the index
  localparam logic [15:0] IDX_CFG = 16'ha031;
  localparam logic [15:0] IDX_LVL0 = 16'ha032;
  localparam logic [15:0] IDX_LVL1 = 16'ha033;
  localparam logic [15:0] IDX_STAT = 16'ha034;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_LVL = 8'h00;
  localparam logic [7:0] LVL_ZERO_VOLT = 8'h00;
  localparam logic [7:0] LVL_FULL_SCALE = 8'hff;
  // configuration bit positions
  localparam int BIT_C_ON = 7;
  localparam int BIT_C_REF = 6;
  localparam int BIT_C_IRQ = 5;
  localparam int BIT_C_INV = 4;
  localparam int BIT_D_ON = 3;
  localparam int BIT_D_REF = 2;
  localparam int BIT_D_IRQ = 1;
  localparam int BIT_D_INV = 0;
  // status bit positions
  localparam int STAT_C_LIVE = 0;
  localparam int STAT_D_LIVE = 1;
  localparam int STAT_C_FLAG = 2;
  localparam int STAT_D_FLAG = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_US = 20;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [15:0] idx);
    return addr == {{(ADDR_W-18){1'b0}}, idx, 2'h0};
  endfunction
endpackage

// File: ccr_channel.sv
// one comparator channel: output conditioning, edge flag, settle timer
`timescale 1ns/1ps
module ccr_channel #(
  parameter int SETTLE_CYCLES = ccr_pkg::SETTLE_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic chanOn,
  input wire logic chanInvert,
  input wire logic irqAllow,
  input wire logic rawIn,
  input wire logic flagClear,
  output logic liveOut,
  output logic edgeFlag,
  output logic irqReq,
  output logic settled
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(SETTLE_CYCLES);

  generate
    if (SETTLE_CYCLES < 1) begin : g_chk
      $error("SETTLE_CYCLES must be at least one");
    end
  endgenerate

  logic live_r, live_nxt;
  logic flag_r, flag_nxt;
  logic irq_r, irq_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;

  always_comb begin
    // disabled comparator reads low whatever the analog side does
    live_nxt = chanOn & (rawIn ^ chanInvert);
    // a toggle in the clearing cycle still sets the flag
    flag_nxt = (chanOn & (live_nxt != live_r)) | (flag_r & ~flagClear);
    irq_nxt = flag_nxt & irqAllow;
    if (!chanOn) begin
      cnt_nxt = '0;
    end else if (cnt_r != CNT_MAX) begin
      cnt_nxt = cnt_r + CW'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      live_r <= 1'b0;
      flag_r <= 1'b0;
      irq_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      live_r <= live_nxt;
      flag_r <= flag_nxt;
      irq_r <= irq_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign liveOut = live_r;
  assign edgeFlag = flag_r;
  assign irqReq = irq_r;
  assign settled = (cnt_r == CNT_MAX);

  off_reads_low_a: assert property (@(posedge ref_clk) disable iff (reset)
    !chanOn |=> !liveOut) else $error("live output high while off");
  toggle_sets_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
    (chanOn && ((rawIn ^ chanInvert) != liveOut)) |=> edgeFlag)
    else $error("toggle did not set edge flag");
  irq_gated_a: assert property (@(posedge ref_clk) disable iff (reset)
    irqReq |-> $past(irqAllow) && edgeFlag)
    else $error("irq raised while not allowed");
  settle_needs_on_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(settled) |-> $past(chanOn) && $past(cnt_r) == CNT_MAX - CW'(1))
    else $error("settled without full count");
  cover_flag_c: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(edgeFlag));
  cover_settle_c: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(settled));
endmodule

// File: ccr_config_regs.sv
// axi4-lite register bank for comparator channels c/d and threshold codes
// How it works
// - config byte, read/write, zero at reset; bits 7..0 C on,ref,irq,inv, D same.
// - channel C on bit set turns comparator C on; clear keeps it off.
// - channel C ref pick 0 uses internal level zero, 1 the external input.
// - channel C irq allow gates whether its edges may request an interrupt.
// - channel C invert bit flips its comparator output when one.
// - channel D irq allow gates whether its edges may request an interrupt.
// - level zero code is eight-bit read/write, 0x00 zero volts, 0xff full scale.
// - level one code is eight-bit read/write and resets to zero.
// - level one only serves channels able to pick it, not C or D.
// - edge flag sets when an enabled channel's live output toggles.
// - live output of a disabled comparator reads zero.
`timescale 1ns/1ps
module ccr_config_regs #(
  parameter int SETTLE_CYCLES = ccr_pkg::SETTLE_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ccr_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ccr_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compCRaw,
  input wire logic compDRaw,
  output logic chanCOn,
  output logic chanCRefPick,
  output logic chanCIrqAllow,
  output logic chanCInvert,
  output logic chanDOn,
  output logic chanDRefPick,
  output logic chanDIrqAllow,
  output logic chanDInvert,
  output logic [7:0] internalLevelZero,
  output logic [7:0] internalLevelOne,
  output logic chanCLiveOut,
  output logic chanDLiveOut,
  output logic chanCEdgeFlag,
  output logic chanDEdgeFlag,
  output logic chanCIrqReq,
  output logic chanDIrqReq,
  output logic chanCSettled,
  output logic chanDSettled
);
  localparam int AW = ccr_pkg::ADDR_W;
  localparam int DW = ccr_pkg::DATA_W;

  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] lvl0_r, lvl0_nxt;
  logic [7:0] lvl1_r, lvl1_nxt;
  logic [AW-1:0] awAddr_r, awAddr_nxt;
  logic awHeld_r, awHeld_nxt;
  logic [7:0] wByte_r, wByte_nxt;
  logic wLane_r, wLane_nxt;
  logic wHeld_r, wHeld_nxt;
  logic bValid_r, bValid_nxt;
  logic [1:0] bResp_r, bResp_nxt;
  logic rValid_r, rValid_nxt;
  logic [1:0] rResp_r, rResp_nxt;
  logic [DW-1:0] rData_r, rData_nxt;
  logic doWrite, wrCfg, wrLvl0, wrLvl1, wrStat, wrHit;
  logic clrC, clrD;
  logic [7:0] statByte;

  // write side: address and data latched separately, in either order
  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign wrCfg = ccr_pkg::addr_hit(awAddr_r, ccr_pkg::IDX_CFG);
  assign wrLvl0 = ccr_pkg::addr_hit(awAddr_r, ccr_pkg::IDX_LVL0);
  assign wrLvl1 = ccr_pkg::addr_hit(awAddr_r, ccr_pkg::IDX_LVL1);
  assign wrStat = ccr_pkg::addr_hit(awAddr_r, ccr_pkg::IDX_STAT);
  assign wrHit = wrCfg || wrLvl0 || wrLvl1 || wrStat;
  // status flags are write-one-to-clear
  assign clrC = doWrite && wrStat && wLane_r && wByte_r[ccr_pkg::STAT_C_FLAG];
  assign clrD = doWrite && wrStat && wLane_r && wByte_r[ccr_pkg::STAT_D_FLAG];

  always_comb begin
    awAddr_nxt = awAddr_r;
    awHeld_nxt = awHeld_r;
    wByte_nxt = wByte_r;
    wLane_nxt = wLane_r;
    wHeld_nxt = wHeld_r;
    bValid_nxt = bValid_r;
    bResp_nxt = bResp_r;
    cfg_nxt = cfg_r;
    lvl0_nxt = lvl0_r;
    lvl1_nxt = lvl1_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awAddr_nxt = s_axi_awaddr;
      awHeld_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wByte_nxt = s_axi_wdata[7:0];
      wLane_nxt = s_axi_wstrb[0];
      wHeld_nxt = 1'b1;
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt = wrHit ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
      if (wLane_r && wrCfg) begin
        cfg_nxt = wByte_r;
      end
      if (wLane_r && wrLvl0) begin
        lvl0_nxt = wByte_r;
      end
      if (wLane_r && wrLvl1) begin
        lvl1_nxt = wByte_r;
      end
    end else if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_r <= ccr_pkg::RST_CFG;
      lvl0_r <= ccr_pkg::RST_LVL;
      lvl1_r <= ccr_pkg::RST_LVL;
      awAddr_r <= '0;
      awHeld_r <= 1'b0;
      wByte_r <= 8'h00;
      wLane_r <= 1'b0;
      wHeld_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= ccr_pkg::RESP_OKAY;
    end else begin
      cfg_r <= cfg_nxt;
      lvl0_r <= lvl0_nxt;
      lvl1_r <= lvl1_nxt;
      awAddr_r <= awAddr_nxt;
      awHeld_r <= awHeld_nxt;
      wByte_r <= wByte_nxt;
      wLane_r <= wLane_nxt;
      wHeld_r <= wHeld_nxt;
      bValid_r <= bValid_nxt;
      bResp_r <= bResp_nxt;
    end
  end

  // read side: one outstanding read, answered the cycle after acceptance
  assign s_axi_arready = !rValid_r;
  always_comb begin
    statByte = 8'h00;
    statByte[ccr_pkg::STAT_C_LIVE] = chanCLiveOut;
    statByte[ccr_pkg::STAT_D_LIVE] = chanDLiveOut;
    statByte[ccr_pkg::STAT_C_FLAG] = chanCEdgeFlag;
    statByte[ccr_pkg::STAT_D_FLAG] = chanDEdgeFlag;
    rValid_nxt = rValid_r;
    rResp_nxt = rResp_r;
    rData_nxt = rData_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_nxt = 1'b1;
      rResp_nxt = ccr_pkg::RESP_OKAY;
      rData_nxt = '0;
      if (ccr_pkg::addr_hit(s_axi_araddr, ccr_pkg::IDX_CFG)) begin
        rData_nxt[7:0] = cfg_r;
      end else if (ccr_pkg::addr_hit(s_axi_araddr, ccr_pkg::IDX_LVL0)) begin
        rData_nxt[7:0] = lvl0_r;
      end else if (ccr_pkg::addr_hit(s_axi_araddr, ccr_pkg::IDX_LVL1)) begin
        rData_nxt[7:0] = lvl1_r;
      end else if (ccr_pkg::addr_hit(s_axi_araddr, ccr_pkg::IDX_STAT)) begin
        rData_nxt[7:0] = statByte;
      end else begin
        rResp_nxt = ccr_pkg::RESP_SLVERR;
      end
    end else if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rValid_r <= 1'b0;
      rResp_r <= ccr_pkg::RESP_OKAY;
      rData_r <= '0;
    end else begin
      rValid_r <= rValid_nxt;
      rResp_r <= rResp_nxt;
      rData_r <= rData_nxt;
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rresp = rResp_r;
  assign s_axi_rdata = rData_r;

  assign chanCOn = cfg_r[ccr_pkg::BIT_C_ON];
  assign chanCRefPick = cfg_r[ccr_pkg::BIT_C_REF];
  assign chanCIrqAllow = cfg_r[ccr_pkg::BIT_C_IRQ];
  assign chanCInvert = cfg_r[ccr_pkg::BIT_C_INV];
  assign chanDOn = cfg_r[ccr_pkg::BIT_D_ON];
  assign chanDRefPick = cfg_r[ccr_pkg::BIT_D_REF];
  assign chanDIrqAllow = cfg_r[ccr_pkg::BIT_D_IRQ];
  assign chanDInvert = cfg_r[ccr_pkg::BIT_D_INV];
  assign internalLevelZero = lvl0_r;
  // c/d cannot reach level one; exported for the a-channel side only
  assign internalLevelOne = lvl1_r;

  ccr_channel #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chan_c (
    .ref_clk(ref_clk),
    .reset(reset),
    .chanOn(chanCOn),
    .chanInvert(chanCInvert),
    .irqAllow(chanCIrqAllow),
    .rawIn(compCRaw),
    .flagClear(clrC),
    .liveOut(chanCLiveOut),
    .edgeFlag(chanCEdgeFlag),
    .irqReq(chanCIrqReq),
    .settled(chanCSettled)
  );

  ccr_channel #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chan_d (
    .ref_clk(ref_clk),
    .reset(reset),
    .chanOn(chanDOn),
    .chanInvert(chanDInvert),
    .irqAllow(chanDIrqAllow),
    .rawIn(compDRaw),
    .flagClear(clrD),
    .liveOut(chanDLiveOut),
    .edgeFlag(chanDEdgeFlag),
    .irqReq(chanDIrqReq),
    .settled(chanDSettled)
  );

  cfg_write_lands_a: assert property (@(posedge ref_clk) disable iff (reset)
    (doWrite && wrCfg && wLane_r) |=> cfg_r == $past(wByte_r))
    else $error("config write not stored");
  cfg_reset_zero_a: assert property (@(posedge ref_clk)
    reset |=> cfg_r == ccr_pkg::RST_CFG && lvl0_r == ccr_pkg::RST_LVL &&
    lvl1_r == ccr_pkg::RST_LVL)
    else $error("registers not zero after reset");
  cfg_holds_a: assert property (@(posedge ref_clk) disable iff (reset)
    !(doWrite && wrCfg && wLane_r) |=> $stable(cfg_r))
    else $error("config changed without write");
  lvl0_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    (doWrite && wrLvl0 && wLane_r) |=> internalLevelZero == $past(wByte_r))
    else $error("level zero write not stored");
  // controls checked against the written byte, not the register itself
  ref_pick_map_a: assert property (@(posedge ref_clk) disable iff (reset)
    (doWrite && wrCfg && wLane_r) |=>
    {chanCOn, chanCRefPick, chanCIrqAllow, chanCInvert,
     chanDOn, chanDRefPick, chanDIrqAllow, chanDInvert} == $past(wByte_r))
    else $error("control bit mapping wrong");
  // only a toggle in the clearing cycle may keep the flag up
  stat_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    clrC |=> !chanCEdgeFlag || $changed(chanCLiveOut))
    else $error("edge flag not cleared");
  bvalid_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_unmapped_a: assert property (@(posedge ref_clk) disable iff (reset)
    (s_axi_arvalid && s_axi_arready &&
     !ccr_pkg::addr_hit(s_axi_araddr, ccr_pkg::IDX_CFG) &&
     !ccr_pkg::addr_hit(s_axi_araddr, ccr_pkg::IDX_LVL0) &&
     !ccr_pkg::addr_hit(s_axi_araddr, ccr_pkg::IDX_LVL1) &&
     !ccr_pkg::addr_hit(s_axi_araddr, ccr_pkg::IDX_STAT))
    |=> s_axi_rvalid && s_axi_rresp == ccr_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  cover_cfg_c: cover property (@(posedge ref_clk) disable iff (reset)
    doWrite && wrCfg);
  cover_stat_c: cover property (@(posedge ref_clk) disable iff (reset)
    s_axi_arvalid && s_axi_arready &&
    ccr_pkg::addr_hit(s_axi_araddr, ccr_pkg::IDX_STAT));
  cover_clear_c: cover property (@(posedge ref_clk) disable iff (reset)
    clrC && chanCEdgeFlag);
endmodule

// File: comparator_cd_config_regs_tb.sv
// self-checking bench for the comparator c/d register bank
`timescale 1ns/1ps
module comparator_cd_config_regs_tb;
  localparam int SETTLE = 8;
  localparam logic [19:0] A_CFG = 20'h280c4;
  localparam logic [19:0] A_LVL0 = 20'h280c8;
  localparam logic [19:0] A_LVL1 = 20'h280cc;
  localparam logic [19:0] A_STAT = 20'h280d0;
  localparam logic [19:0] A_BAD = 20'h00010;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [19:0] awaddr = 20'h0, araddr = 20'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic compCRaw = 1'b0, compDRaw = 1'b0;
  wire [7:0] cfgOut;
  logic [7:0] lvl0, lvl1;
  logic cLive, dLive, cFlag, dFlag, cIrq, dIrq, cSettled, dSettled;
  logic [31:0] rd;
  logic [1:0] rsp;
  int errors = 0;
  int testsRun = 0;

  always #2 ref_clk = ~ref_clk;

  ccr_config_regs #(.SETTLE_CYCLES(SETTLE)) ccr_config_regs_i (
    .ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .compCRaw(compCRaw), .compDRaw(compDRaw),
    .chanCOn(cfgOut[7]), .chanCRefPick(cfgOut[6]),
    .chanCIrqAllow(cfgOut[5]), .chanCInvert(cfgOut[4]),
    .chanDOn(cfgOut[3]), .chanDRefPick(cfgOut[2]),
    .chanDIrqAllow(cfgOut[1]), .chanDInvert(cfgOut[0]),
    .internalLevelZero(lvl0), .internalLevelOne(lvl1),
    .chanCLiveOut(cLive), .chanDLiveOut(dLive),
    .chanCEdgeFlag(cFlag), .chanDEdgeFlag(dFlag),
    .chanCIrqReq(cIrq), .chanDIrqReq(dIrq),
    .chanCSettled(cSettled), .chanDSettled(dSettled)
  );

  task automatic finish_test();
    if (errors == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes are judged with the values that stand at the rising edge;
  // the design updates by non-blocking assignment, so no race
  task automatic axi_write(input logic [19:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] resp);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge ref_clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awDone = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    bready <= 1'b1;
    @(posedge ref_clk);
    while (bvalid !== 1'b1) begin
      @(posedge ref_clk);
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [19:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge ref_clk);
    while (arready !== 1'b1) begin
      @(posedge ref_clk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    @(posedge ref_clk);
    while (rvalid !== 1'b1) begin
      @(posedge ref_clk);
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    axi_write(a, d, 4'hf, rsp);
    chk({30'h0, rsp}, {30'h0, ccr_pkg::RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
    axi_read(a, rd, rsp);
    chk(rd, exp);
    chk({30'h0, rsp}, {30'h0, ccr_pkg::RESP_OKAY});
  endtask

  // live, flag and irq outputs settle one cycle after the raw or config change; settled takes SETTLE cycles
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("Error %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    int i;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd_chk(A_CFG, 32'h0);
    rd_chk(A_LVL0, 32'h0);
    rd_chk(A_LVL1, 32'h0);
    for (i = 0; i < 8; i++) begin
      wr(A_CFG, 32'h1 << i);
      rd_chk(A_CFG, 32'h1 << i);
      chk({24'h0, cfgOut}, 32'h1 << i);
    end
    wr(A_CFG, 32'hffffff5a);
    rd_chk(A_CFG, 32'h5a);
    chk({24'h0, cfgOut}, 32'h5a);
    axi_write(A_CFG, 32'ha5, 4'he, rsp);
    chk({30'h0, rsp}, {30'h0, ccr_pkg::RESP_OKAY});
    rd_chk(A_CFG, 32'h5a);
    wr(A_LVL0, {24'h0, ccr_pkg::LVL_FULL_SCALE});
    rd_chk(A_LVL0, 32'hff);
    chk({24'h0, lvl0}, 32'hff);
    wr(A_LVL1, 32'h3c);
    rd_chk(A_LVL1, 32'h3c);
    chk({24'h0, lvl1}, 32'h3c);
    chk({24'h0, lvl0}, 32'hff);
    axi_write(A_BAD, 32'h77, 4'hf, rsp);
    chk({30'h0, rsp}, {30'h0, ccr_pkg::RESP_SLVERR});
    axi_read(A_BAD, rd, rsp);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, {30'h0, ccr_pkg::RESP_SLVERR});
    // channel c: enable with interrupts allowed, let the bias settle
    wr(A_CFG, 32'ha0);
    i = 0;
    while (cSettled !== 1'b1 && i < 100) begin
      @(posedge ref_clk);
      i++;
    end
    chk({31'h0, cSettled}, 32'h1);
    chk({29'h0, cIrq, cFlag, cLive}, 32'h0);
    compCRaw <= 1'b1;
    wait_cyc(3);
    chk({29'h0, cIrq, cFlag, cLive}, 32'h7);
    rd_chk(A_STAT, 32'h5);
    wr(A_STAT, 32'h4);
    chk({31'h0, cFlag}, 32'h0);
    wr(A_CFG, 32'hb0);
    wait_cyc(3);
    chk({29'h0, cIrq, cFlag, cLive}, 32'h6);
    wr(A_STAT, 32'h4);
    wr(A_CFG, 32'h90);
    compCRaw <= 1'b0;
    wait_cyc(3);
    chk({29'h0, cIrq, cFlag, cLive}, 32'h3);
    wr(A_STAT, 32'h4);
    wr(A_CFG, 32'h10);
    wait_cyc(3);
    chk({29'h0, cIrq, cFlag, cLive}, 32'h0);
    chk({31'h0, cSettled}, 32'h0);
    // channel d mirrors c
    wr(A_CFG, 32'h0a);
    // d is not trusted before its bias has settled
    wait_cyc(SETTLE + 1);
    chk({31'h0, dSettled}, 32'h1);
    compDRaw <= 1'b1;
    wait_cyc(3);
    chk({29'h0, dIrq, dFlag, dLive}, 32'h7);
    rd_chk(A_STAT, 32'ha);
    wr(A_STAT, 32'h8);
    wr(A_CFG, 32'h09);
    wait_cyc(3);
    chk({29'h0, dIrq, dFlag, dLive}, 32'h2);
    wr(A_CFG, 32'h0);
    wait_cyc(3);
    chk({31'h0, dLive}, 32'h0);
    chk({31'h0, dSettled}, 32'h0);
    // unused threshold codes parked at zero to save power
    wr(A_LVL0, 32'h0);
    wr(A_LVL1, 32'h0);
    chk({16'h0, lvl1, lvl0}, 32'h0);
    finish_test();
  end
endmodule
